/* File: bench/hbp_host_model.sv */
// host processor model: parallel reads and writes, serial master frames
// assumes pins driven on falling edges of sys_clk_i; serial clock 80 ns
`timescale 1ns/1ps
module hbp_host_model (
  // clock and observed pins
  input logic sys_clk_i,
  input logic pol_i,
  input logic wait_i,
  input logic [15:0] data_i,
  input logic so_i,
  input logic so_oe_i,
  input logic oe_i,
  // driven pins
  output logic ce_n_o,
  output logic rw_we_n_o,
  output logic strobe_n_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o,
  output logic sck_o,
  output logic si_o
);
  // idle levels
  initial
  begin
    ce_n_o = 1'b1; rw_we_n_o = 1'b1; strobe_n_o = 1'b1;
    addr_o = 16'h0000; data_o = 16'h0000; sck_o = 1'b0; si_o = 1'b0;
  end
  // read: address set as chip enable falls, then hold until wait clears
  task rd(input logic [15:0] a, output logic [15:0] d, output logic seen);
    integer i;
    logic act, done;
    begin
      @(negedge sys_clk_i) addr_o = a;
      ce_n_o = 1'b0;
      @(negedge sys_clk_i) strobe_n_o = 1'b0;
      seen = 1'b0;
      done = 1'b0;
      for (i = 0; i < 40 && !done; i = i + 1)
      begin
        @(negedge sys_clk_i) act = (wait_i === pol_i);
        if (act) seen = 1'b1;
        if (i >= 5 && !act) done = 1'b1;
      end
      d = (done && oe_i) ? data_i : 16'hXXXX;
      strobe_n_o = 1'b1;
      @(negedge sys_clk_i) ce_n_o = 1'b1;
      repeat (3) @(negedge sys_clk_i);
    end
  endtask
  // write in either strobe style
  task wr(input logic [15:0] a, input logic [15:0] w, input logic sep);
    begin
      @(negedge sys_clk_i) addr_o = a;
      data_o = w;
      @(negedge sys_clk_i) ce_n_o = 1'b0;
      rw_we_n_o = sep;
      @(negedge sys_clk_i) if (sep) rw_we_n_o = 1'b0; else strobe_n_o = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      if (sep) rw_we_n_o = 1'b1; else strobe_n_o = 1'b1;
      @(negedge sys_clk_i) rw_we_n_o = 1'b1;
      ce_n_o = 1'b1;
      repeat (8) @(negedge sys_clk_i);
    end
  endtask
  // one serial bit, mode 0: sample before the rising edge
  task sbit(input logic b, output logic r);
    begin
      si_o = b;
      repeat (4) @(negedge sys_clk_i);
      r = so_oe_i ? so_i : 1'bx;
      sck_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      sck_o = 1'b0;
    end
  endtask
  // command word, turnaround on reads, one data word
  task sframe(input logic [15:0] cmd, input logic [15:0] w, output logic [15:0] r);
    integer i;
    logic x;
    begin
      @(negedge sys_clk_i) ce_n_o = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      for (i = 15; i >= 0; i = i - 1) sbit(cmd[i], x);
      if (cmd[15]) repeat (8) sbit(1'b0, x);
      for (i = 15; i >= 0; i = i - 1) sbit(w[i], r[i]);
      si_o = 1'b0;
      repeat (8) @(negedge sys_clk_i);
      ce_n_o = 1'b1;
      repeat (8) @(negedge sys_clk_i);
    end
  endtask
endmodule // hbp_host_model

/* File: bench/hbp_host_port_asserts.sv */
// checker for the host port top: wait level, prefetch, byte lanes, serial enable
// assumes binding onto hbp_host_port, every signal on sys_clk_i
`timescale 1ns/1ps
`include "hbp_defines.vh"
module hbp_host_port_asserts (
  // clock and reset
  input logic sys_clk_i,
  input logic rst_n_i,
  // pins
  input logic port_sel_i,
  input logic bus_width_sel_i,
  input logic strobe_style_sel_i,
  input logic wait_polarity_sel_i,
  input logic ce_n_i,
  input logic rw_we_n_i,
  input logic common_strobe_n_i,
  input logic [15:0] data_o,
  input logic data_oe_o,
  input logic wait_o,
  input logic so_oe_o,
  // fabric
  input logic fab_req_o,
  input logic fab_we_o,
  input logic [`HBP_AW-1:0] fab_addr_o,
  input logic fab_ack_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wact;
  logic [`HBP_AW-1:0] rd_addr;
  logic pol_q1;
  logic pol_q2;
  // polarity pin seen with the same two-stage lag as the port
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pol_q1 <= 1'b0;
      pol_q2 <= 1'b0;
    end
    else
    begin
      pol_q1 <= wait_polarity_sel_i;
      pol_q2 <= pol_q1;
    end
  end
  // wait active in either polarity
  assign wact = (wait_o == pol_q2);
  // address of the last acknowledged transfer
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_addr <= '0;
    else if (fab_ack_i && fab_req_o)
      rd_addr <= fab_addr_o;
  end
  AST_IDLE_LEVEL: assert property (
    ce_n_i && $past(ce_n_i, 2) && $past(ce_n_i, 4) && $past(wait_polarity_sel_i, 4) == wait_polarity_sel_i
    |-> wait_o == !wait_polarity_sel_i) else $error("wait not at idle level");
  AST_WAIT_FETCH: assert property (
    wact |-> ##[0:2] (fab_req_o && !fab_we_o)) else $error("wait without fetch");
  AST_NEXT_FETCH: assert property (
    port_sel_i && fab_ack_i && fab_req_o && !fab_we_o && wact
    |=> ##[0:4] (fab_req_o && !fab_we_o && fab_addr_o == rd_addr + 15'h0001)) else $error("no prefetch");
  AST_NO_STROBE_WAIT: assert property (
    common_strobe_n_i && $past(common_strobe_n_i, 1) && $past(common_strobe_n_i, 2) && $past(common_strobe_n_i, 3)
    |-> !wact) else $error("wait while idle");
  AST_NARROW_LANE: assert property (
    data_oe_o && $past(data_oe_o, 1) && !wact && !bus_width_sel_i |-> data_o[15:8] == 8'h00)
    else $error("upper lane not clear");
  AST_WRITE_ISSUE: assert property (
    port_sel_i && !strobe_style_sel_i && !rw_we_n_i && $rose(common_strobe_n_i)
    |-> ##[1:6] (fab_req_o && fab_we_o)) else $error("write not issued");
  AST_SO_RELEASE: assert property (
    ce_n_i && $past(ce_n_i, 1) && $past(ce_n_i, 2) && $past(ce_n_i, 3) |-> !so_oe_o) else $error("so driven");
  AST_PAR_NO_SO: assert property (
    port_sel_i && $past(port_sel_i, 3) |-> !so_oe_o) else $error("so driven in parallel mode");
  AST_SPI_CE: assert property (
    !port_sel_i && !$past(port_sel_i, 4) && ce_n_i && $past(ce_n_i, 3) |-> !fab_req_o)
    else $error("serial access without enable");
endmodule // hbp_host_port_asserts

bind hbp_host_port hbp_host_port_asserts u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .port_sel_i(port_sel_i),
  .bus_width_sel_i(bus_width_sel_i), .strobe_style_sel_i(strobe_style_sel_i),
  .wait_polarity_sel_i(wait_polarity_sel_i), .ce_n_i(ce_n_i), .rw_we_n_i(rw_we_n_i),
  .common_strobe_n_i(common_strobe_n_i), .data_o(data_o), .data_oe_o(data_oe_o), .wait_o(wait_o),
  .so_oe_o(so_oe_o), .fab_req_o(fab_req_o), .fab_we_o(fab_we_o), .fab_addr_o(fab_addr_o), .fab_ack_i(fab_ack_i));

/* File: bench/hbp_host_port_test.sv */
// testbench for the host port: prefetch, write invalidation, lanes, serial port
// assumes the host model drives pins and a one-cycle ack fabric memory here
`timescale 1ns/1ps
module hbp_host_port_test;
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic port_sel = 1'b1, bw = 1'b1, style = 1'b1, bo = 1'b0, pol = 1'b0;
  logic ce_n, rw_we_n, strobe_n, sck, si, so, so_oe, data_oe, wait_w, fab_req, fab_we, fab_ack = 1'b0;
  logic [15:0] addr, wdat, rdat, fab_wdata, fab_rdata = 16'h0000, last_wd = 16'h0000, d;
  logic [14:0] fab_addr, last_wa = 15'h0000;
  logic [15:0] mem [0:15];
  logic seen;
  integer failures = 0, n_checks = 0, j;
  // clock
  always #5 sys_clk = ~sys_clk;
  // fabric memory answering with a one-cycle ack
  always @(negedge sys_clk)
  begin
    fab_ack <= 1'b0;
    if (fab_req && !fab_ack)
    begin
      fab_ack <= 1'b1;
      fab_rdata <= mem[fab_addr[3:0]];
      if (fab_we)
      begin
        mem[fab_addr[3:0]] <= fab_wdata;
        last_wa <= fab_addr;
        last_wd <= fab_wdata;
      end
    end
  end
  hbp_host_port u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .port_sel_i(port_sel), .bus_width_sel_i(bw),
    .strobe_style_sel_i(style), .byte_order_sel_i(bo), .wait_polarity_sel_i(pol), .ce_n_i(ce_n),
    .rw_we_n_i(rw_we_n), .common_strobe_n_i(strobe_n), .addr_i(addr), .data_i(wdat), .data_o(rdat),
    .data_oe_o(data_oe), .wait_o(wait_w), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .fab_req_o(fab_req), .fab_we_o(fab_we), .fab_addr_o(fab_addr), .fab_wdata_o(fab_wdata),
    .fab_ack_i(fab_ack), .fab_rdata_i(fab_rdata));
  hbp_host_model u_host (.sys_clk_i(sys_clk), .pol_i(pol), .wait_i(wait_w), .data_i(rdat), .so_i(so), .oe_i(data_oe),
    .so_oe_i(so_oe), .ce_n_o(ce_n), .rw_we_n_o(rw_we_n), .strobe_n_o(strobe_n), .addr_o(addr),
    .data_o(wdat), .sck_o(sck), .si_o(si));
  // memory contents with distinct bytes per word
  function automatic logic [15:0] fexp(input logic [3:0] i);
    fexp = {4'hA, i, 4'h5, i};
  endfunction
  task chk_data(input logic [15:0] got, input logic [15:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        failures++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk_flag(input logic got, input logic exp);
    chk_data({15'h0000, got}, {15'h0000, exp});
  endtask
  task cfg(input logic p, input logic w, input logic o, input logic s, input logic l);
    begin
      @(negedge sys_clk) port_sel = p;
      bw = w; bo = o; style = s; pol = l;
      repeat (6) @(negedge sys_clk);
    end
  endtask
  // first read waits, the prefetched next word comes late without wait
  task t_prefetch;
    begin
      cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      u_host.rd(16'h0004, d, seen);
      chk_data(d, fexp(4'h2));
      chk_flag(seen, 1'b1);
      chk_flag(data_oe, 1'b0);
      repeat (30) @(negedge sys_clk);
      u_host.rd(16'h0006, d, seen);
      chk_data(d, fexp(4'h3));
      chk_flag(seen, 1'b0);
    end
  endtask
  // a write between reads breaks the chain
  task t_write;
    begin
      cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      u_host.rd(16'h0008, d, seen);
      chk_data(d, fexp(4'h4));
      chk_flag(seen, 1'b0);
      u_host.wr(16'h0012, 16'h1234, 1'b0);
      chk_data({1'b0, last_wa}, 16'h0009);
      chk_data(last_wd, 16'h1234);
      u_host.rd(16'h000A, d, seen);
      chk_data(d, fexp(4'h5));
      chk_flag(seen, 1'b1);
    end
  endtask
  // high wait polarity, swapped word, then every narrow lane case
  task t_order;
    begin
      cfg(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
      u_host.rd(16'h000F, d, seen);
      chk_data(d, {fexp(4'h7) >> 8} | {fexp(4'h7) << 8});
      chk_flag(seen, 1'b1);
      for (j = 0; j < 4; j++)
      begin
        cfg(1'b1, 1'b0, j[1], 1'b1, 1'b0);
        u_host.rd({15'h0008, j[0]}, d, seen);
        chk_data(d, (j[0] == j[1]) ? 16'h0058 : 16'h00A8);
      end
    end
  endtask
  // two narrow bytes with separate strobes merge into one word, then read back
  task t_byte_write;
    begin
      cfg(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      u_host.wr(16'h0018, 16'h00C3, 1'b1);
      u_host.wr(16'h0019, 16'h003C, 1'b1);
      chk_data({1'b0, last_wa}, 16'h000C);
      chk_data(last_wd, 16'hC33C);
      u_host.rd(16'h0018, d, seen);
      chk_data(d, 16'h00C3);
      chk_flag(seen, 1'b1);
    end
  endtask
  // serial write then read back through the slave port
  task t_spi;
    begin
      cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      u_host.sframe(16'h000A, 16'hBEEF, d);
      chk_data({1'b0, last_wa}, 16'h000A);
      chk_data(last_wd, 16'hBEEF);
      u_host.sframe(16'h800A, 16'h0000, d);
      chk_data(d, 16'hBEEF);
      chk_flag(so_oe, 1'b0);
    end
  endtask
  task end_sim;
    begin
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // main sequence
  initial
  begin
    for (j = 0; j < 16; j++) mem[j] = fexp(j[3:0]);
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_prefetch;
    t_write;
    t_order;
    t_byte_write;
    t_spi;
    end_sim;
  end
endmodule // hbp_host_port_test

/* File: hw/hbp_defines.vh */
// constants shared by the host port top and its serial slave
// assumes inclusion by bare name from files under hw/
`ifndef HBP_DEFINES_VH
`define HBP_DEFINES_VH

// word and address widths of the internal fabric
`define HBP_DW 16
`define HBP_AW 15
`define HBP_BYTE_W 8

// parallel fabric sequencer states
`define HBP_ST_IDLE 2'h0
`define HBP_ST_RD 2'h1
`define HBP_ST_PF 2'h2
`define HBP_ST_WR 2'h3

// serial frame: 16-bit command, bit 15 set means read, then turnaround on reads
`define HBP_SPI_RD_BIT 15
`define HBP_SPI_WORD_LAST 4'hF
`define HBP_SPI_TURN_LAST 4'h7
`define HBP_SPI_PH_CMD 2'h0
`define HBP_SPI_PH_TURN 2'h1
`define HBP_SPI_PH_DATA 2'h2

`endif

/* File: hw/hbp_host_port.v */
// host port top: parallel bus with wait and prefetch, plus serial slave
// assumes pins asynchronous to sys_clk_i; fabric on sys_clk_i answering with a one-cycle ack
`timescale 1ns/1ps
`include "hbp_defines.vh"

module hbp_host_port (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // configuration pins
  input wire port_sel_i,
  input wire bus_width_sel_i,
  input wire strobe_style_sel_i,
  input wire byte_order_sel_i,
  input wire wait_polarity_sel_i,
  // parallel bus pins
  input wire ce_n_i,
  input wire rw_we_n_i,
  input wire common_strobe_n_i,
  input wire [15:0] addr_i,
  input wire [15:0] data_i,
  output reg [15:0] data_o,
  output wire data_oe_o,
  output wire wait_o,
  // serial pins
  input wire sck_i,
  input wire si_i,
  output wire so_o,
  output wire so_oe_o,
  // internal fabric
  output wire fab_req_o,
  output wire fab_we_o,
  output wire [`HBP_AW-1:0] fab_addr_o,
  output wire [`HBP_DW-1:0] fab_wdata_o,
  input wire fab_ack_i,
  input wire [`HBP_DW-1:0] fab_rdata_i
);

  reg [39:0] sync1;
  reg [39:0] sync2;
  reg rd_q;
  reg wr_q;
  reg [1:0] state;
  reg par_req;
  reg par_we;
  reg [`HBP_AW-1:0] par_addr;
  reg [`HBP_DW-1:0] par_wdata;
  reg rd_pend;
  reg [`HBP_AW-1:0] rd_addr;
  reg rd_a0;
  reg cur_valid;
  reg [`HBP_AW-1:0] cur_addr;
  reg [`HBP_DW-1:0] cur_data;
  reg pf_valid;
  reg pf_need;
  reg pf_cancel;
  reg [`HBP_AW-1:0] pf_addr;
  reg [`HBP_DW-1:0] pf_data;
  reg wr_pend;
  reg [`HBP_AW-1:0] wr_addr;
  reg [`HBP_DW-1:0] wr_word;
  reg [`HBP_DW-1:0] wbuf;
  reg [15:0] wr_bus_data;
  reg [15:0] wr_bus_addr;
  wire s_port;
  wire s_bw;
  wire s_ss;
  wire s_bo;
  wire s_wp;
  wire s_ce_n;
  wire s_rw;
  wire s_strb;
  wire [15:0] s_addr;
  wire [15:0] s_data;
  wire rd_act;
  wire wr_act;
  wire rd_start;
  wire wr_end;
  wire [`HBP_AW-1:0] word_addr;
  wire cur_hit;
  wire pf_hit;
  wire low_lane;
  wire [`HBP_DW-1:0] merged;
  wire spi_req;
  wire spi_we;
  wire [`HBP_AW-1:0] spi_addr;
  wire [`HBP_DW-1:0] spi_wdata;

  // byte placement of an internal word onto the host data bus
  function [15:0] hbp_lane;
    input [15:0] word;
    input bw;
    input bo;
    input a0;
    begin
      if (bw)
        hbp_lane = bo ? {word[7:0], word[15:8]} : word;
      else
        hbp_lane = (a0 == bo) ? {8'h00, word[7:0]} : {8'h00, word[15:8]};
    end
  endfunction

  // two-stage synchronisers on every parallel and configuration pin
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= 40'h0700000000;
      sync2 <= 40'h0700000000;
    end
    else
    begin
      sync1 <= {port_sel_i, bus_width_sel_i, strobe_style_sel_i, byte_order_sel_i,
                wait_polarity_sel_i, ce_n_i, rw_we_n_i, common_strobe_n_i, addr_i, data_i};
      sync2 <= sync1;
    end
  end

  assign s_port = sync2[39];
  assign s_bw = sync2[38];
  assign s_ss = sync2[37];
  assign s_bo = sync2[36];
  assign s_wp = sync2[35];
  assign s_ce_n = sync2[34];
  assign s_rw = sync2[33];
  assign s_strb = sync2[32];
  assign s_addr = sync2[31:16];
  assign s_data = sync2[15:0];

  // strobe decode; style high uses separate strobes, low uses strobe plus direction
  assign rd_act = s_port & ~s_ce_n & (s_ss ? ~s_strb : (~s_strb & s_rw));
  assign wr_act = s_port & ~s_ce_n & (s_ss ? ~s_rw : (~s_strb & ~s_rw));
  assign rd_start = rd_act & ~rd_q;
  assign wr_end = wr_q & ~wr_act;
  assign word_addr = s_addr[15:1];
  assign cur_hit = cur_valid & (cur_addr == word_addr);
  assign pf_hit = pf_valid & (pf_addr == word_addr);

  // write data placement: 8-bit bytes merge into the held word
  assign low_lane = (wr_bus_addr[0] == s_bo);
  assign merged = low_lane ? {wbuf[15:8], wr_bus_data[7:0]} : {wr_bus_data[7:0], wbuf[7:0]};

  // output drive and wait level
  assign data_oe_o = rd_act;
  assign wait_o = s_wp ? (rd_pend & s_port) : ~(rd_pend & s_port);

  // strobe history and write capture while the write strobe is active
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wr_bus_data <= 16'h0000;
      wr_bus_addr <= 16'h0000;
    end
    else
    begin
      rd_q <= rd_act;
      wr_q <= wr_act;
      if (wr_act)
      begin
        wr_bus_data <= s_data;
        wr_bus_addr <= s_addr;
      end
    end
  end

  // parallel sequencer: pending write, first read, then prefetch
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= `HBP_ST_IDLE;
      par_req <= 1'b0;
      par_we <= 1'b0;
      par_addr <= 15'h0000;
      par_wdata <= 16'h0000;
      rd_pend <= 1'b0;
      rd_addr <= 15'h0000;
      rd_a0 <= 1'b0;
      cur_valid <= 1'b0;
      cur_addr <= 15'h0000;
      cur_data <= 16'h0000;
      pf_valid <= 1'b0;
      pf_need <= 1'b0;
      pf_cancel <= 1'b0;
      pf_addr <= 15'h0000;
      pf_data <= 16'h0000;
      wr_pend <= 1'b0;
      wr_addr <= 15'h0000;
      wr_word <= 16'h0000;
      wbuf <= 16'h0000;
      data_o <= 16'h0000;
    end
    else
    begin
      case (state)
        `HBP_ST_IDLE:
        begin
          pf_cancel <= 1'b0;
          if (wr_pend)
          begin
            state <= `HBP_ST_WR;
            par_req <= 1'b1;
            par_we <= 1'b1;
            par_addr <= wr_addr;
            par_wdata <= wr_word;
          end
          else if (rd_pend)
          begin
            state <= `HBP_ST_RD;
            par_req <= 1'b1;
            par_we <= 1'b0;
            par_addr <= rd_addr;
          end
          else if (pf_need)
          begin
            state <= `HBP_ST_PF;
            pf_need <= 1'b0;
            par_req <= 1'b1;
            par_we <= 1'b0;
            par_addr <= pf_addr;
          end
        end
        `HBP_ST_RD:
        begin
          if (fab_ack_i)
          begin
            // first word arrives: serve it and chain the next address
            state <= `HBP_ST_IDLE;
            par_req <= 1'b0;
            rd_pend <= 1'b0;
            cur_valid <= 1'b1;
            cur_addr <= rd_addr;
            cur_data <= fab_rdata_i;
            data_o <= hbp_lane(fab_rdata_i, s_bw, s_bo, rd_a0);
            pf_need <= 1'b1;
            pf_addr <= rd_addr + 15'h0001;
          end
        end
        `HBP_ST_PF:
        begin
          if (fab_ack_i)
          begin
            state <= `HBP_ST_IDLE;
            par_req <= 1'b0;
            pf_data <= fab_rdata_i;
            pf_valid <= ~pf_cancel;
          end
        end
        `HBP_ST_WR:
        begin
          if (fab_ack_i)
          begin
            state <= `HBP_ST_IDLE;
            par_req <= 1'b0;
            wr_pend <= 1'b0;
          end
        end
        default:
          state <= `HBP_ST_IDLE;
      endcase
      // host read start: serve from held words or wait for a fetch
      if (rd_start)
      begin
        rd_a0 <= s_addr[0];
        if (cur_hit)
          data_o <= hbp_lane(cur_data, s_bw, s_bo, s_addr[0]);
        else if (pf_hit)
        begin
          data_o <= hbp_lane(pf_data, s_bw, s_bo, s_addr[0]);
          cur_valid <= 1'b1;
          cur_addr <= pf_addr;
          cur_data <= pf_data;
          pf_valid <= 1'b0;
          pf_need <= 1'b1;
          pf_addr <= pf_addr + 15'h0001;
        end
        else
        begin
          rd_pend <= 1'b1;
          rd_addr <= word_addr;
          cur_valid <= 1'b0;
          pf_valid <= 1'b0;
          pf_need <= 1'b0;
          pf_cancel <= 1'b1;
        end
      end
      // host write end: break the prefetch chain and queue the word, narrow writes only on the odd byte
      if (wr_end)
      begin
        cur_valid <= 1'b0;
        pf_valid <= 1'b0;
        pf_need <= 1'b0;
        pf_cancel <= 1'b1;
        if (s_bw)
        begin
          wr_pend <= 1'b1;
          wr_addr <= wr_bus_addr[15:1];
          wr_word <= s_bo ? {wr_bus_data[7:0], wr_bus_data[15:8]} : wr_bus_data;
        end
        else
        begin
          wbuf <= merged;
          if (wr_bus_addr[0])
          begin
            wr_pend <= 1'b1;
            wr_addr <= wr_bus_addr[15:1];
            wr_word <= merged;
          end
        end
      end
    end
  end

  // serial slave, enabled only while port select is low
  hbp_spi_slave u_spi (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(~s_port),
    .ce_n_i(ce_n_i),
    .sck_i(sck_i),
    .si_i(si_i),
    .so_o(so_o),
    .so_oe_o(so_oe_o),
    .req_o(spi_req),
    .we_o(spi_we),
    .addr_o(spi_addr),
    .wdata_o(spi_wdata),
    .ack_i(fab_ack_i & ~s_port),
    .rdata_i(fab_rdata_i)
  );

  // fabric mux by port select
  assign fab_req_o = s_port ? par_req : spi_req;
  assign fab_we_o = s_port ? par_we : spi_we;
  assign fab_addr_o = s_port ? par_addr : spi_addr;
  assign fab_wdata_o = s_port ? par_wdata : spi_wdata;

endmodule // hbp_host_port

/* File: hw/hbp_spi_slave.v */
// serial slave of the host port: command word, turnaround byte on reads, data words
// assumes raw pins on its inputs and a fabric that answers within a turnaround byte
`timescale 1ns/1ps
`include "hbp_defines.vh"

module hbp_spi_slave (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // enable from port select
  input wire enable_i,
  // serial pins
  input wire ce_n_i,
  input wire sck_i,
  input wire si_i,
  output reg so_o,
  output wire so_oe_o,
  // fabric side
  output reg req_o,
  output reg we_o,
  output reg [`HBP_AW-1:0] addr_o,
  output reg [`HBP_DW-1:0] wdata_o,
  input wire ack_i,
  input wire [`HBP_DW-1:0] rdata_i
);

  reg [2:0] sync1;
  reg [2:0] sync2;
  reg sck_q;
  reg [1:0] phase;
  reg [3:0] bitcnt;
  reg is_rd;
  reg skip_fall;
  reg [`HBP_DW-1:0] sh_in;
  reg [`HBP_DW-1:0] sh_out;
  reg [`HBP_DW-1:0] rd_buf;
  reg [`HBP_AW-1:0] cursor;
  wire active;
  wire sck_rise;
  wire sck_fall;
  wire [`HBP_DW-1:0] word_in;

  // two-stage synchronisers for chip enable, clock and data pins
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= 3'h1;
      sync2 <= 3'h1;
      sck_q <= 1'b0;
    end
    else
    begin
      sync1 <= {si_i, sck_i, ce_n_i};
      sync2 <= sync1;
      sck_q <= sync2[1];
    end
  end

  assign active = enable_i & ~sync2[0];
  assign sck_rise = active & sync2[1] & ~sck_q;
  assign sck_fall = active & ~sync2[1] & sck_q;
  assign word_in = {sh_in[`HBP_DW-2:0], sync2[2]};
  assign so_oe_o = active & is_rd & (phase == `HBP_SPI_PH_DATA);

  // frame decode, shifting and fabric requests
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase <= `HBP_SPI_PH_CMD;
      bitcnt <= 4'h0;
      is_rd <= 1'b0;
      skip_fall <= 1'b0;
      sh_in <= 16'h0000;
      sh_out <= 16'h0000;
      rd_buf <= 16'h0000;
      cursor <= 15'h0000;
      so_o <= 1'b0;
      req_o <= 1'b0;
      we_o <= 1'b0;
      addr_o <= 15'h0000;
      wdata_o <= 16'h0000;
    end
    else
    begin
      if (ack_i)
      begin
        req_o <= 1'b0;
        if (!we_o)
          rd_buf <= rdata_i;
      end
      if (!active)
      begin
        // frame ends when chip enable rises
        phase <= `HBP_SPI_PH_CMD;
        bitcnt <= 4'h0;
        is_rd <= 1'b0;
      end
      else if (sck_rise)
      begin
        // mode 0: master data sampled on rising edge
        sh_in <= word_in;
        bitcnt <= bitcnt + 4'h1;
        case (phase)
          `HBP_SPI_PH_CMD:
          begin
            if (bitcnt == `HBP_SPI_WORD_LAST)
            begin
              bitcnt <= 4'h0;
              cursor <= word_in[`HBP_AW-1:0];
              is_rd <= word_in[`HBP_SPI_RD_BIT];
              if (word_in[`HBP_SPI_RD_BIT])
              begin
                phase <= `HBP_SPI_PH_TURN;
                req_o <= 1'b1;
                we_o <= 1'b0;
                addr_o <= word_in[`HBP_AW-1:0];
              end
              else
                phase <= `HBP_SPI_PH_DATA;
            end
          end
          `HBP_SPI_PH_TURN:
          begin
            if (bitcnt == `HBP_SPI_TURN_LAST)
            begin
              bitcnt <= 4'h0;
              phase <= `HBP_SPI_PH_DATA;
              sh_out <= rd_buf;
              so_o <= rd_buf[`HBP_DW-1];
              skip_fall <= 1'b1;
              cursor <= cursor + 15'h0001;
              req_o <= 1'b1;
              we_o <= 1'b0;
              addr_o <= cursor + 15'h0001;
            end
          end
          `HBP_SPI_PH_DATA:
          begin
            if (bitcnt == `HBP_SPI_WORD_LAST)
            begin
              bitcnt <= 4'h0;
              cursor <= cursor + 15'h0001;
              req_o <= 1'b1;
              if (is_rd)
              begin
                // next word already fetched, reload and prefetch again
                sh_out <= rd_buf;
                so_o <= rd_buf[`HBP_DW-1];
                skip_fall <= 1'b1;
                we_o <= 1'b0;
                addr_o <= cursor + 15'h0001;
              end
              else
              begin
                we_o <= 1'b1;
                addr_o <= cursor;
                wdata_o <= word_in;
              end
            end
          end
          default:
            phase <= `HBP_SPI_PH_CMD;
        endcase
      end
      else if (sck_fall && is_rd && phase == `HBP_SPI_PH_DATA)
      begin
        // shift out on falling edge, except the one right after a load
        if (skip_fall)
          skip_fall <= 1'b0;
        else
        begin
          sh_out <= {sh_out[`HBP_DW-2:0], 1'b0};
          so_o <= sh_out[`HBP_DW-2];
        end
      end
    end
  end

endmodule // hbp_spi_slave
